/* File: lbfs_defs.svh */
/*
 * Timing counts and interrupt/register layout for the boost LED fault supervisor.
 * Assumes a 200 MHz core clock; counts other than LBFS_STARTUP_CYC derive from times given in their own units.
 */
`ifndef LBFS_DEFS_SVH
`define LBFS_DEFS_SVH

`define LBFS_CLK_MHZ          200
`define LBFS_OCP_SHUT_NS      3000
`define LBFS_OCP_SHUT_CYC     ((`LBFS_OCP_SHUT_NS * `LBFS_CLK_MHZ) / 1000)
`define LBFS_UV_FILT_US       50
`define LBFS_UV_FILT_CYC      (`LBFS_UV_FILT_US * `LBFS_CLK_MHZ)
`define LBFS_CLR_HOLD_MS      16
`define LBFS_CLR_HOLD_CYC     (`LBFS_CLR_HOLD_MS * 1000 * `LBFS_CLK_MHZ)
`define LBFS_STARTUP_CYC      4096
`define LBFS_OV_RESUME_PCT    97

`define LBFS_REG_CTRL         12'h000
`define LBFS_REG_STATUS       12'h004
`define LBFS_REG_IRQ_STAT     12'h008
`define LBFS_REG_IRQ_MASK     12'h00c
`define LBFS_REG_OV_LEVEL     12'h010

`define LBFS_EV_OV            0
`define LBFS_EV_SWOV          1
`define LBFS_EV_SWOC          2
`define LBFS_EV_SWLIM2        3
`define LBFS_EV_INOC          4
`define LBFS_EV_UV            5
`define LBFS_EV_W             6

`define LBFS_CTRL_RST         8'h00
`define LBFS_MASK_RST         6'h00

`endif

/* File: lbfs_pkg.sv */
/*
 * Types shared by the boost LED fault supervisor.
 * Assumes lbfs_defs.svh supplies the numeric layout.
 */
`default_nettype none
package lbfs_pkg;
    // Comparator trips from the power stage, raw and asynchronous
    typedef struct packed {
        logic output_overvoltage_trip;
        logic switch_node_overvoltage_trip;
        logic switch_overcurrent_trip;
        logic secondary_switch_current_limit;
        logic input_overcurrent_trip;
        logic supply_good;
        logic sense_good;
    } lbfs_trip_t;

    // Gating outputs toward the power stage
    typedef struct packed {
        logic       boost_enable;
        logic [3:0] sink_enable;
        logic       input_disconnect_switch_on;
    } lbfs_gate_t;

    typedef enum logic [3:0] {
        LBFS_OFF     = 4'b0001,
        LBFS_START   = 4'b0010,
        LBFS_RUN     = 4'b0100,
        LBFS_LATCHED = 4'b1000
    } lbfs_state_t;
endpackage
`default_nettype wire

/* File: lbfs_supervisor.sv */
/*
 * Fault supervisor for a boost LED driver: gates boost, sinks and input disconnect switch,
 * latches severe faults, flags the host; registers over AXI4-Lite.
 * Assumes trip inputs are raw comparator levels and enable/dimming are host levels.
 */
`timescale 1ns/1ps
`default_nettype none
`include "lbfs_defs.svh"

module lbfs_supervisor
#(
    parameter int NUM_SINKS   = 4,
    parameter int UV_CYC      = `LBFS_UV_FILT_CYC,
    parameter int CLR_CYC     = `LBFS_CLR_HOLD_CYC,
    parameter int START_CYC   = `LBFS_STARTUP_CYC
)
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // Power stage
    input  wire lbfs_pkg::lbfs_trip_t trip_raw,
    input  wire logic [3:0]          sink_has_current,
    input  wire logic                ov_below_resume,
    input  wire logic                cycle_start,
    // Host pins and power-stage gates
    input  wire logic                enable_in,
    input  wire logic                dimming_in,
    output var  logic                fault_n,
    output var  lbfs_pkg::lbfs_gate_t gate,
    // AXI4-Lite slave
    input  wire logic [11:0]         s_awaddr,
    input  wire logic                s_awvalid,
    output var  logic                s_awready,
    input  wire logic [31:0]         s_wdata,
    input  wire logic [3:0]          s_wstrb,
    input  wire logic                s_wvalid,
    output var  logic                s_wready,
    output var  logic [1:0]          s_bresp,
    output var  logic                s_bvalid,
    input  wire logic                s_bready,
    input  wire logic [11:0]         s_araddr,
    input  wire logic                s_arvalid,
    output var  logic                s_arready,
    output var  logic [31:0]         s_rdata,
    output var  logic [1:0]          s_rresp,
    output var  logic                s_rvalid,
    input  wire logic                s_rready,
    // Interrupt
    output var  logic                irq
);
    import lbfs_pkg::*;

    // Elaboration check: sink count is fixed by the gate struct
    if (NUM_SINKS != 4 || UV_CYC < 2 || CLR_CYC < 2 || START_CYC < 2)
    begin : g_param_check
        $error("lbfs_supervisor: unsupported parameter values");
    end

    localparam int TW = $bits(lbfs_trip_t);

    // Two-flop synchroniser; stage one is read only by stage two
    logic [TW-1:0] sync1;
    logic [TW-1:0] sync2;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync1 <= '0;
            sync2 <= '0;
        end
        else
        begin
            sync1 <= trip_raw;
            sync2 <= sync1;
        end
    end
    lbfs_trip_t t;
    assign t = sync2;

    // Software control: bit0 soft enable, bit1 startup mask enable
    logic [7:0] ctrl;
    wire        soft_en   = ctrl[0];
    wire        start_msk = ctrl[1];

    // Undervoltage filter and enable qualification
    logic [31:0] uv_cnt;
    logic        uv_ok;
    wire         both_good = t.supply_good & t.sense_good;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            uv_cnt <= '0;
            uv_ok  <= 1'b0;
        end
        else if (both_good)
        begin
            uv_cnt <= '0;
            uv_ok  <= 1'b1;
        end
        else if (!t.supply_good && uv_ok)
        begin
            // Short dips are ignored until the count runs out
            if (uv_cnt >= 32'(UV_CYC))
                uv_ok <= 1'b0;
            else
                uv_cnt <= uv_cnt + 32'h1;
        end
        else
            uv_cnt <= '0;
    end

    // Clear filter: enable or dimming low for the hold time
    logic [31:0] clr_cnt;
    logic        clr_pulse;
    wire         host_low = !enable_in || !dimming_in;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            clr_cnt   <= '0;
            clr_pulse <= 1'b0;
        end
        else
        begin
            clr_pulse <= host_low && (clr_cnt == 32'(CLR_CYC - 1));
            clr_cnt   <= !host_low ? '0 :
                         (clr_cnt == 32'(CLR_CYC)) ? clr_cnt : clr_cnt + 32'h1;
        end
    end

    // State machine
    lbfs_state_t state;
    lbfs_state_t next_state;
    logic [31:0] st_cnt;
    wire         masking   = (state == LBFS_START) && start_msk;
    wire         ev_swov   = t.switch_node_overvoltage_trip && !masking;
    wire         ev_lim2   = t.secondary_switch_current_limit;
    wire         ev_inoc   = t.input_overcurrent_trip;
    wire         latch_ev  = ev_swov || ev_lim2 || ev_inoc;
    wire         run_ok    = uv_ok && enable_in && soft_en;

    always_comb
    begin
        next_state = state;
        case (state)
            LBFS_OFF:     next_state = run_ok ? LBFS_START : LBFS_OFF;
            LBFS_START:   next_state = latch_ev ? LBFS_LATCHED :
                                       !run_ok ? LBFS_OFF :
                                       (st_cnt >= 32'(START_CYC)) ? LBFS_RUN : LBFS_START;
            LBFS_RUN:     next_state = latch_ev ? LBFS_LATCHED :
                                       !run_ok ? LBFS_OFF : LBFS_RUN;
            LBFS_LATCHED: next_state = clr_pulse ? LBFS_OFF : LBFS_LATCHED;
            default:      next_state = LBFS_OFF;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state  <= LBFS_OFF;
            st_cnt <= '0;
        end
        else
        begin
            state  <= next_state;
            st_cnt <= (next_state != state) ? '0 : st_cnt + 32'h1;
        end
    end

    // Overvoltage hysteresis: halt until below resume level
    logic ov_hold;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ov_hold <= 1'b0;
        else if (t.output_overvoltage_trip)
            ov_hold <= 1'b1;
        else if (ov_below_resume)
            ov_hold <= 1'b0;
    end

    // Cycle skip after primary current limit
    logic [1:0] skip;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            skip <= 2'h0;
        else if (t.switch_overcurrent_trip)
            skip <= 2'h2;
        else if (cycle_start && skip != 2'h0)
            skip <= skip - 2'h1;
    end

    // Strings dropped at overvoltage stay out until the state machine returns to LBFS_OFF
    logic [3:0] dropped;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            dropped <= 4'h0;
        else if (state == LBFS_OFF)
            dropped <= 4'h0;
        else if (t.output_overvoltage_trip)
            dropped <= dropped | ~sink_has_current;
    end

    // Gate outputs registered; latched state drops everything at once
    wire active  = (state == LBFS_START) || (state == LBFS_RUN);
    wire kill    = latch_ev || !active;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            gate    <= '0;
            fault_n <= 1'b1;
        end
        else
        begin
            gate.boost_enable <= !kill && !ov_hold && !t.output_overvoltage_trip
                                 && (skip == 2'h0) && !t.switch_overcurrent_trip;
            gate.sink_enable  <= kill ? 4'h0 : ~dropped;
            // Gate off in the same edge as shutdown, well inside 3 us
            gate.input_disconnect_switch_on <= !kill;
            fault_n <= !(next_state == LBFS_LATCHED);
        end
    end

    // Sticky interrupt status, write one to clear; set wins
    logic [5:0] irq_stat;
    logic [5:0] irq_mask;
    wire  [5:0] ev_vec = {!both_good, ev_inoc, ev_lim2, t.switch_overcurrent_trip,
                          ev_swov, t.output_overvoltage_trip};
    logic       wr_fire;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    wire        clr_irq = wr_fire && (wr_addr == `LBFS_REG_IRQ_STAT);
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq_stat <= 6'h00;
            irq      <= 1'b0;
        end
        else
        begin
            irq_stat <= ev_vec | (irq_stat & ~(clr_irq ? wr_data[5:0] : 6'h00));
            irq      <= |(irq_stat & irq_mask);
        end
    end

    // AXI4-Lite write: take address and data in either order
    logic aw_have;
    logic w_have;
    assign wr_fire = aw_have && w_have && !s_bvalid;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            aw_have <= 1'b0;
            w_have  <= 1'b0;
            wr_addr <= 12'h000;
            wr_data <= 32'h0;
            s_bvalid <= 1'b0;
            s_bresp  <= 2'h0;
            ctrl     <= `LBFS_CTRL_RST;
            irq_mask <= `LBFS_MASK_RST;
            s_awready <= 1'b1;
            s_wready  <= 1'b1;
        end
        else
        begin
            if (s_awvalid && s_awready)
            begin
                aw_have <= 1'b1;
                wr_addr <= s_awaddr;
                s_awready <= 1'b0;
            end
            if (s_wvalid && s_wready)
            begin
                w_have  <= 1'b1;
                wr_data <= s_wdata;
                s_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_have  <= 1'b0;
                w_have   <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp  <= 2'h0;
                case (wr_addr)
                    `LBFS_REG_CTRL:     ctrl     <= wr_data[7:0];
                    `LBFS_REG_IRQ_MASK: irq_mask <= wr_data[5:0];
                    `LBFS_REG_IRQ_STAT: ;
                    default:            s_bresp  <= 2'h2;
                endcase
            end
            else if (s_bvalid && s_bready)
            begin
                // Readies reopen only once the response is gone
                s_bvalid  <= 1'b0;
                s_awready <= 1'b1;
                s_wready  <= 1'b1;
            end
        end
    end

    // AXI4-Lite read; status shows live state, gates and flags
    wire [31:0] status_word = {16'h0, fault_n, gate.input_disconnect_switch_on,
                               gate.sink_enable, gate.boost_enable, uv_ok, dropped, state};
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_rvalid <= 1'b0;
            s_rdata  <= 32'h0;
            s_rresp  <= 2'h0;
            s_arready <= 1'b1;
        end
        else if (s_arvalid && s_arready)
        begin
            s_rvalid <= 1'b1;
            s_arready <= 1'b0;
            s_rresp  <= 2'h0;
            case (s_araddr)
                `LBFS_REG_CTRL:     s_rdata <= {24'h0, ctrl};
                `LBFS_REG_STATUS:   s_rdata <= status_word;
                `LBFS_REG_IRQ_STAT: s_rdata <= {26'h0, irq_stat};
                `LBFS_REG_IRQ_MASK: s_rdata <= {26'h0, irq_mask};
                default:
                begin
                    s_rdata <= 32'h0;
                    s_rresp <= 2'h2;
                end
            endcase
        end
        else if (s_rvalid && s_rready)
        begin
            s_rvalid  <= 1'b0;
            s_arready <= 1'b1;   // Held in a flop so the port comes from a register
        end
    end

    // Assertions
    sequence seq_latch_trip;
        active && (ev_lim2 || ev_inoc);
    endsequence
    sequence seq_all_off;
        !gate.boost_enable && gate.sink_enable == 4'h0 && !gate.input_disconnect_switch_on;
    endsequence

    AST_OV_NO_LATCH: assert property (@(posedge clk) disable iff (rst)
        (state == LBFS_RUN && t.output_overvoltage_trip && !latch_ev) |=> state != LBFS_LATCHED)
        else $error("overvoltage latched the device");
    AST_OV_STOPS_BOOST: assert property (@(posedge clk) disable iff (rst)
        t.output_overvoltage_trip |=> !gate.boost_enable)
        else $error("boost ran during overvoltage");
    AST_DROP_STRING: assert property (@(posedge clk) disable iff (rst)
        (state != LBFS_OFF && t.output_overvoltage_trip && !sink_has_current[0] && !latch_ev)
        |=> ##1 !gate.sink_enable[0])
        else $error("dead string kept in regulation");
    AST_OV_RESUME: assert property (@(posedge clk) disable iff (rst)
        (ov_hold && ov_below_resume && !t.output_overvoltage_trip) |=> !ov_hold)
        else $error("boost did not resume");
    AST_SWOV_LATCH: assert property (@(posedge clk) disable iff (rst)
        (active && ev_swov) |=> seq_all_off ##1 state == LBFS_LATCHED)
        else $error("switch-node overvoltage not latched");
    AST_SKIP: assert property (@(posedge clk) disable iff (rst)
        t.switch_overcurrent_trip |=> !gate.boost_enable && skip == 2'h2)
        else $error("current limit did not end cycle");
    AST_LATCH_OFF: assert property (@(posedge clk) disable iff (rst)
        seq_latch_trip |=> seq_all_off ##1 (state == LBFS_LATCHED && !fault_n))
        else $error("latching trip did not shut down");
    AST_INOC_TIME: assert property (@(posedge clk) disable iff (rst)
        (active && ev_inoc) |-> ##[1:2] !gate.input_disconnect_switch_on)
        else $error("input overcurrent shutdown too slow");
    AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (rst)
        (state == LBFS_LATCHED && !clr_pulse) |=> state == LBFS_LATCHED)
        else $error("latch left without clear");
    AST_ENABLE_GOOD: assert property (@(posedge clk) disable iff (rst)
        $rose(state == LBFS_START) |-> $past(uv_ok))
        else $error("started without supply good");
endmodule // lbfs_supervisor
`default_nettype wire

/* File: lbfs_stage_model.sv */
/*
 * Host and power-stage partner for the LED boost fault supervisor: host enable and
 * dimming levels, plus a free-running switching-cycle pulse.
 * Assumes the bench requests the host level through host_on after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module lbfs_stage_model
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Bench request
    input  wire logic host_on,
    input  wire logic dim_on,
    // Toward the supervisor
    output var  logic enable_in,
    output var  logic dimming_in,
    output var  logic cycle_start
);
    logic [2:0] phase;

    // Host pins are registered, so a low request lasts whole cycles; clearing needs long lows
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            enable_in  <= 1'b0;
            dimming_in <= 1'b1;
        end
        else
        begin
            enable_in  <= host_on;
            dimming_in <= dim_on;
        end
    end

    // Switching cycle every 8 clocks, one-cycle pulse
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            phase       <= 3'h0;
            cycle_start <= 1'b0;
        end
        else
        begin
            phase       <= phase + 3'h1;
            cycle_start <= (phase == 3'h7);
        end
    end
endmodule // lbfs_stage_model
`default_nettype wire

/* File: test_led_boost_fault_supervisor.sv */
/*
 * Self-checking bench for the LED boost fault supervisor.
 * Assumes lbfs_stage_model as host partner and short counts set by parameter.
 */
`timescale 1ns/1ps
`default_nettype none
`include "lbfs_defs.svh"
module test_led_boost_fault_supervisor;
    import lbfs_pkg::*;
    // Bench signals; every bench-driven one except wr_resp given a value at time zero, DUT outputs not
    logic clk = 1'b0, rst = 1'b1, host_on = 1'b0, ov_below_resume = 1'b0, dim_on = 1'b1;
    logic enable_in, dimming_in, cycle_start, fault_n, irq;
    lbfs_trip_t trip_raw = '0;
    lbfs_gate_t gate;
    logic [3:0] sink_has_current = 4'hf, s_wstrb = 4'hf;
    logic [11:0] s_awaddr = '0, s_araddr = '0;
    logic [31:0] s_wdata = '0, s_rdata;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0] s_bresp, s_rresp, wr_resp;
    int error_cnt = 0, total_checks = 0;

    always #2.5 clk = ~clk;

    lbfs_stage_model i_host (.clk, .rst, .host_on, .dim_on, .enable_in, .dimming_in,
        .cycle_start);

    lbfs_supervisor #(.UV_CYC(20), .CLR_CYC(50), .START_CYC(16)) i_dut (.clk, .rst, .trip_raw,
        .sink_has_current, .ov_below_resume, .cycle_start, .enable_in, .dimming_in, .fault_n,
        .gate, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
        .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
        .s_rvalid, .s_rready, .irq);

    // Verdict and end of run
    task automatic finish_test();
        $display("checks %0d, errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            error_cnt++;
        end
    endtask

    task automatic hang(input string what);
        $display("unexpected %s: expected done, seen timeout", what);
        error_cnt++;
        finish_test();
    endtask

    // AXI4-Lite write: address and data offered together, each released once taken
    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        s_awaddr  <= a;
        s_wdata   <= d;
        s_awvalid <= 1'b1;
        s_wvalid  <= 1'b1;
        s_bready  <= 1'b1;
        repeat (200)
        begin
            @(posedge clk);
            if (s_awvalid && s_awready)
                s_awvalid <= 1'b0;
            if (s_wvalid && s_wready)
                s_wvalid <= 1'b0;
            if (s_bvalid === 1'b1)
            begin
                wr_resp = s_bresp;
                s_bready <= 1'b0;
                return;
            end
        end
        hang("write response");
    endtask

    // AXI4-Lite read
    task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_araddr  <= a;
        s_arvalid <= 1'b1;
        s_rready  <= 1'b1;
        repeat (200)
        begin
            @(posedge clk);
            if (s_arvalid && s_arready)
                s_arvalid <= 1'b0;
            if (s_rvalid === 1'b1)
            begin
                d = s_rdata;
                r = s_rresp;
                s_rready <= 1'b0;
                return;
            end
        end
        hang("read data");
    endtask

    task automatic wait_boost(input logic v, input int lim);
        repeat (lim)
        begin
            @(posedge clk);
            if (gate.boost_enable === v)
                return;
        end
        hang("boost_enable");
    endtask

    // Reset values, register defaults and an unmapped address
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0]  r;
        @(posedge clk);
        chk("gate", 32'(gate), 32'h0);
        chk("fault_n", 32'(fault_n), 32'h1);
        axr(`LBFS_REG_CTRL, d, r);
        chk("ctrl", d, 32'h0);
        axr(12'hffc, d, r);
        chk("unmapped resp", 32'(r), 32'h2);
        axw(12'hffc, 32'h0);
        chk("unmapped wr resp", 32'(wr_resp), 32'h2);
        axw(`LBFS_REG_IRQ_MASK, 32'h3f);
        chk("mask wr resp", 32'(wr_resp), 32'h0);
        axr(`LBFS_REG_IRQ_MASK, d, r);
        chk("irq mask", d, 32'h3f);
    endtask

    // Startup needs both good levels; switch-node trip masked during startup
    task automatic t_start();
        @(posedge clk);
        host_on <= 1'b1;
        trip_raw.supply_good <= 1'b1;
        axw(`LBFS_REG_CTRL, 32'h3);
        repeat (40) @(posedge clk);
        chk("boost sense low", 32'(gate.boost_enable), 32'h0);
        trip_raw.sense_good <= 1'b1;
        repeat (6) @(posedge clk);
        trip_raw.switch_node_overvoltage_trip <= 1'b1;
        repeat (2) @(posedge clk);
        trip_raw.switch_node_overvoltage_trip <= 1'b0;
        wait_boost(1'b1, 100);
        chk("fault_n start", 32'(fault_n), 32'h1);
        chk("sinks", 32'(gate.sink_enable), 32'hf);
        axw(`LBFS_REG_CTRL, 32'h1);
        axw(`LBFS_REG_IRQ_STAT, 32'h3f);
        repeat (3) @(posedge clk);
        chk("irq cleared", 32'(irq), 32'h0);
    endtask

    // Output overvoltage: boost stops, dead string dropped, resume below 97 percent
    task automatic t_ovp();
        logic [31:0] d;
        logic [1:0]  r;
        axw(`LBFS_REG_IRQ_MASK, 32'h0);
        trip_raw.output_overvoltage_trip <= 1'b1;
        sink_has_current <= 4'b1011;
        repeat (6) @(posedge clk);
        chk("boost ovp", 32'(gate.boost_enable), 32'h0);
        chk("sinks ovp", 32'(gate.sink_enable), 32'hb);
        chk("fault_n ovp", 32'(fault_n), 32'h1);
        chk("irq masked", 32'(irq), 32'h0);
        trip_raw.output_overvoltage_trip <= 1'b0;
        sink_has_current <= 4'hf;
        repeat (6) @(posedge clk);
        chk("boost above resume", 32'(gate.boost_enable), 32'h0);
        ov_below_resume <= 1'b1;
        wait_boost(1'b1, 20);
        chk("sinks resumed", 32'(gate.sink_enable), 32'hb);
        // Flag, switch on, sinks 1011, boost, supply ok, dropped 0100, running
        axr(`LBFS_REG_STATUS, d, r);
        chk("status", d, 32'hef44);
        axw(`LBFS_REG_IRQ_MASK, 32'h3f);
        repeat (3) @(posedge clk);
        chk("irq unmasked", 32'(irq), 32'h1);
        axw(`LBFS_REG_IRQ_STAT, 32'h3f);
        repeat (3) @(posedge clk);
        chk("irq w1c", 32'(irq), 32'h0);
    endtask

    // Current limit: cycle ended and next one skipped, then normal switching
    task automatic t_ocp();
        trip_raw.switch_overcurrent_trip <= 1'b1;
        @(posedge clk);
        trip_raw.switch_overcurrent_trip <= 1'b0;
        repeat (5) @(posedge clk);
        chk("boost ocp", 32'(gate.boost_enable), 32'h0);
        chk("fault_n ocp", 32'(fault_n), 32'h1);
        wait_boost(1'b1, 30);
    endtask

    // Latching trips: all gates off, flag, latch held until a long host low
    task automatic t_latch();
        logic [6:0]  m [3] = '{7'h20, 7'h08, 7'h04};
        int          b [3] = '{1, 3, 4};
        logic [31:0] d;
        logic [1:0]  r;
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk);
            trip_raw <= lbfs_trip_t'(7'(trip_raw) | m[i]);
            repeat (2) @(posedge clk);
            trip_raw <= lbfs_trip_t'(7'(trip_raw) & ~m[i]);
            repeat (3) @(posedge clk);
            chk("gate latch", 32'(gate), 32'h0);
            chk("fault_n latch", 32'(fault_n), 32'h0);
            chk("irq latch", 32'(irq), 32'h1);
            repeat (30) @(posedge clk);
            chk("gate held", 32'(gate), 32'h0);
            axr(`LBFS_REG_IRQ_STAT, d, r);
            chk("irq stat bit", 32'(d[b[i]]), 32'h1);
            axw(`LBFS_REG_IRQ_STAT, 32'h3f);
            repeat (3) @(posedge clk);
            chk("irq w1c", 32'(irq), 32'h0);
            host_on <= 1'b0;
            repeat (20) @(posedge clk);
            host_on <= 1'b1;
            repeat (5) @(posedge clk);
            chk("fault_n short low", 32'(fault_n), 32'h0);
            // Second pass clears through the dimming pin instead
            if (i == 1)
                dim_on <= 1'b0;
            else
                host_on <= 1'b0;
            repeat (60) @(posedge clk);
            host_on <= 1'b1;
            dim_on  <= 1'b1;
            wait_boost(1'b1, 100);
            chk("fault_n cleared", 32'(fault_n), 32'h1);
        end
    endtask

    // Supply dips: short ones ignored, long ones turn the device off
    task automatic t_uv();
        trip_raw.supply_good <= 1'b0;
        repeat (10) @(posedge clk);
        trip_raw.supply_good <= 1'b1;
        repeat (5) @(posedge clk);
        chk("boost short dip", 32'(gate.boost_enable), 32'h1);
        trip_raw.supply_good <= 1'b0;
        repeat (40) @(posedge clk);
        chk("boost long dip", 32'(gate.boost_enable), 32'h0);
        trip_raw.supply_good <= 1'b1;
    endtask

    // Main sequence
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_start();
        t_ovp();
        t_ocp();
        t_latch();
        t_uv();
        finish_test();
    end
endmodule // test_led_boost_fault_supervisor
`default_nettype wire
